/* rtl/hcp_host_port.sv */
// Summary of operation
// [R01] interrupt pin is open drain, low only
// [R02] interrupt low while unmasked indication pending
// [R03] select low enables port, high ignored
// [R04] host raises select once after power-up
// [R05] fresh select fall per access
// [R06] parallel address picks the register
// [R07] host grounds address pins in serial
// [R08] data bus writes in, driven on reads
// [R09] serial reply leaves on data bit zero
// [R10] style pin picks strobe style in parallel
// [R11] style pin ignored in serial mode
// [R12] direction high reads, low writes
// [R13] split style: shared pin is write strobe
// [R14] serial: shared pin shifts command in
// [R15] mode pin: low parallel, high serial
// [R16] strobe pin: data or read strobe
// [R17] sample rising clock, update falling clock
// [R18] data bus undriven except during reads
`default_nettype none
module hcp_host_port
  import hcp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic chipSelN,
  input wire logic transfer_strobe_n,
  input wire logic rwWrSerialCmdIn,
  input wire logic serial_port_mode_sel,
  input wire logic parallel_style_sel,
  input wire logic [hcp_pkg::ADDR_W-1:0] addrIn,
  input wire logic [hcp_pkg::DATA_W-1:0] dataIn,
  output logic [hcp_pkg::DATA_W-1:0] dataOut,
  output logic [hcp_pkg::DATA_W-1:0] dataOe,
  output hcp_pkg::hcp_req_t regReq,
  input wire logic [hcp_pkg::DATA_W-1:0] regRdData,
  input wire logic irqPending,
  output logic intOut,
  output logic intOe,
  output logic testModeActive
);
  import hcp_pkg::*;

  // ========================================================================
  // pin synchronisation
  hcp_pins_t pinsAsync; // raw pin bundle
  hcp_pins_t pins; // synchronised bundle
  hcp_pins_t prev_q; // previous synchronised bundle
  logic [PIN_W-1:0] pinsVec; // flat synchronised bundle

  assign pinsAsync = '{chipSelN: chipSelN, strobeN: transfer_strobe_n,
                       rwSdi: rwWrSerialCmdIn, portMode: serial_port_mode_sel,
                       styleSel: parallel_style_sel, addr: addrIn,
                       data: dataIn};

  hcp_sync #(
    .WIDTH(PIN_W)
  ) uSync (
    .clk(clk),
    .nrst(nrst),
    .async(pinsAsync),
    .synced(pinsVec)
  );
  assign pins = hcp_pins_t'(pinsVec);

  // history register for edge detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= '0; // matches synchroniser reset, no false edge
    end else begin
      prev_q <= pins;
    end
  end

  // ========================================================================
  // edge and mode decode
  logic selected; // port enabled
  logic strobeFall; // strobe or read strobe asserted
  logic strobeRise; // strobe or read strobe released
  logic wrRise; // split style write strobe released
  logic sclkRise; // serial clock rising
  logic sclkFall; // serial clock falling
  logic serialMode; // port in serial mode
  logic splitStyle; // split strobe style

  assign selected = !pins.chipSelN; // R03
  assign serialMode = (pins.portMode == MODE_SERIAL); // R15
  assign splitStyle = (pins.styleSel == STYLE_SPLIT_STROBE); // R10
  assign strobeFall = prev_q.strobeN && !pins.strobeN; // R16
  assign strobeRise = !prev_q.strobeN && pins.strobeN; // R16
  assign wrRise = !prev_q.rwSdi && pins.rwSdi; // R13
  assign sclkRise = !prev_q.strobeN && pins.strobeN;
  assign sclkFall = prev_q.strobeN && !pins.strobeN;

  // ========================================================================
  // test mode clear on first select high
  logic testMode_q; // internal test mode latched from reset
  logic testMode_d;

  // next test mode value
  always_comb begin
    testMode_d = testMode_q;
    if (pins.chipSelN) begin
      testMode_d = 1'b0; // R04
    end
  end

  // test mode register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      testMode_q <= 1'b1;
    end else begin
      testMode_q <= testMode_d;
    end
  end
  assign testModeActive = testMode_q;

  // ========================================================================
  // parallel access engine
  hcp_pstate_t pState_q; // parallel access state
  hcp_pstate_t pState_d;
  logic [DATA_W-1:0] rdData_q; // parallel read data
  logic [DATA_W-1:0] rdData_d;
  logic rdDrive_q; // data bus drive enable
  logic rdDrive_d;
  hcp_req_t pReq; // parallel request, one cycle pulses
  logic captureRd_q; // read strobe issued last cycle
  logic captureRd_d;

  // next parallel state
  always_comb begin
    pState_d = pState_q;
    rdData_d = rdData_q;
    captureRd_d = 1'b0;
    pReq = '{we: 1'b0, re: 1'b0, addr: pins.addr, wdata: pins.data}; // R06
    if (!selected || serialMode) begin
      pState_d = PP_IDLE; // R03
    end else begin
      case (pState_q)
        PP_IDLE: begin
          // idle only follows select high, so every access is fresh
          if (strobeFall && (splitStyle || pins.rwSdi == DIR_READ)) begin
            pState_d = PP_READ; // R12
            pReq.re = 1'b1;
            captureRd_d = 1'b1;
          end else if (strobeFall) begin
            pState_d = PP_WRITE; // R12
          end else if (splitStyle && !pins.rwSdi) begin
            pState_d = PP_WRITE; // R13
          end
        end
        PP_READ: begin
          if (strobeRise) begin
            pState_d = PP_DONE; // R05
          end
        end
        PP_WRITE: begin
          // data latched on trailing edge of the strobe in use
          if ((splitStyle && wrRise) || (!splitStyle && strobeRise)) begin
            pReq.we = 1'b1; // R08
            pState_d = PP_DONE;
          end
        end
        PP_DONE: begin
          pState_d = PP_DONE; // R05
        end
        default: begin
          pState_d = PP_IDLE;
        end
      endcase
    end
    if (captureRd_q) begin
      rdData_d = regRdData; // R08
    end
  end

  // drive only while a read is running under select
  always_comb begin
    rdDrive_d = 1'b0;
    if (pState_d == PP_READ && selected && !serialMode) begin
      rdDrive_d = 1'b1; // R18
    end
  end

  // parallel registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pState_q <= PP_IDLE;
      rdData_q <= DATA_RST;
      rdDrive_q <= 1'b0;
      captureRd_q <= 1'b0;
    end else begin
      pState_q <= pState_d;
      rdData_q <= rdData_d;
      rdDrive_q <= rdDrive_d;
      captureRd_q <= captureRd_d;
    end
  end

  // ========================================================================
  // serial access engine
  logic [4:0] bitCnt_q; // serial bits received this frame
  logic [4:0] bitCnt_d;
  logic [SPI_ALL_BITS-1:0] shiftIn_q; // serial command shift register
  logic [SPI_ALL_BITS-1:0] shiftIn_d;
  logic [DATA_W-1:0] shiftOut_q; // serial reply shift register
  logic [DATA_W-1:0] shiftOut_d;
  logic serial_reply_out_q; // serial reply bit on data bit zero
  logic serial_reply_out_d;
  logic loadReply_q; // reply load pending
  logic loadReply_d;
  logic replyLive_q; // reply shifting in progress
  logic replyLive_d;
  hcp_req_t sReq; // serial request

  // next serial values
  always_comb begin
    bitCnt_d = bitCnt_q;
    shiftIn_d = shiftIn_q;
    shiftOut_d = shiftOut_q;
    serial_reply_out_d = serial_reply_out_q;
    loadReply_d = 1'b0;
    replyLive_d = replyLive_q;
    sReq = '{we: 1'b0, re: 1'b0, addr: shiftIn_q[ADDR_W-1:0],
             wdata: shiftIn_q[DATA_W-1:0]};
    if (!selected || !serialMode) begin
      bitCnt_d = CNT_RST; // R03
      replyLive_d = 1'b0;
    end else begin
      if (sclkRise && bitCnt_q < SPI_ALL_CNT) begin
        // style pin plays no part here
        shiftIn_d = {shiftIn_q[SPI_ALL_BITS-2:0], pins.rwSdi}; // R14 R11 R17
        bitCnt_d = bitCnt_q + 5'h01;
      end
      if (bitCnt_q == SPI_CMD_CNT && prev_q != pins && sclkRise == 1'b0
          && loadReply_q == 1'b0 && replyLive_q == 1'b0
          && shiftIn_q[SPI_CMD_BITS-1] == SPI_READ_BIT) begin
        // address complete: fetch the register
        sReq.re = 1'b1;
        sReq.addr = shiftIn_q[ADDR_W-1:0];
        loadReply_d = 1'b1;
      end
      if (loadReply_q) begin
        // msb goes out at once, the rest on the following falls
        serial_reply_out_d = regRdData[DATA_W-1]; // R09
        shiftOut_d = {regRdData[DATA_W-2:0], 1'b0};
        replyLive_d = 1'b1;
      end
      if (sclkFall && replyLive_q) begin
        serial_reply_out_d = shiftOut_q[DATA_W-1]; // R17 R09
        shiftOut_d = {shiftOut_q[DATA_W-2:0], 1'b0};
      end
      if (sclkRise && bitCnt_q == SPI_ALL_CNT - 5'h01
          && shiftIn_q[SPI_ALL_BITS-2] != SPI_READ_BIT) begin
        // final data bit: commit the write
        sReq.we = 1'b1;
        sReq.addr = shiftIn_q[SPI_ALL_BITS-3 -: ADDR_W];
        sReq.wdata = {shiftIn_q[DATA_W-2:0], pins.rwSdi};
      end
    end
  end

  // serial registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bitCnt_q <= CNT_RST;
      shiftIn_q <= '0;
      shiftOut_q <= DATA_RST;
      serial_reply_out_q <= 1'b0;
      loadReply_q <= 1'b0;
      replyLive_q <= 1'b0;
    end else begin
      bitCnt_q <= bitCnt_d;
      shiftIn_q <= shiftIn_d;
      shiftOut_q <= shiftOut_d;
      serial_reply_out_q <= serial_reply_out_d;
      loadReply_q <= loadReply_d;
      replyLive_q <= replyLive_d;
    end
  end

  // ========================================================================
  // outputs
  // request mux by port mode
  assign regReq = serialMode ? sReq : pReq; // R15

  // data bus: parallel read data or serial reply on bit zero
  always_comb begin
    dataOut = rdData_q;
    dataOe = {DATA_W{rdDrive_q}}; // R18 R08
    if (serialMode) begin
      dataOut = {{(DATA_W-1){1'b0}}, serial_reply_out_q}; // R09
      dataOe = {{(DATA_W-1){1'b0}}, selected && replyLive_q};
    end
  end

  // open drain interrupt: pull low only
  assign intOut = 1'b0; // R01
  assign intOe = irqPending; // R02
endmodule
`default_nettype wire

/* include/hcp_pkg.sv */
`default_nettype none
// ==========================================================================
// host cpu port shared definitions
package hcp_pkg;
  // bus widths
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  // serial frame layout: one read/write bit, address msb first, then data
  localparam int SPI_CMD_BITS = 1 + ADDR_W;
  localparam int SPI_ALL_BITS = SPI_CMD_BITS + DATA_W;
  localparam logic [4:0] SPI_CMD_CNT = 5'h0c;
  localparam logic [4:0] SPI_ALL_CNT = 5'h14;
  localparam logic SPI_READ_BIT = 1'b1;
  // level encodings of the mode pins
  localparam logic STYLE_DIR_STROBE = 1'b0;
  localparam logic STYLE_SPLIT_STROBE = 1'b1;
  localparam logic MODE_PARALLEL = 1'b0;
  localparam logic MODE_SERIAL = 1'b1;
  localparam logic DIR_READ = 1'b1;
  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [4:0] CNT_RST = 5'h00;

  // pin bundle after synchronisation
  typedef struct packed {
    logic chipSelN;
    logic strobeN;
    logic rwSdi;
    logic portMode;
    logic styleSel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hcp_pins_t;
  localparam int PIN_W = $bits(hcp_pins_t);

  // register access request toward the register file
  typedef struct packed {
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hcp_req_t;

  // parallel access states
  typedef enum logic [1:0] {
    PP_IDLE,
    PP_READ,
    PP_WRITE,
    PP_DONE
  } hcp_pstate_t;
endpackage
`default_nettype wire

/* rtl/hcp_sync.sv */
`default_nettype none
// ==========================================================================
// two flip-flop synchroniser, one stage pair per bit
module hcp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by second stage
  logic [WIDTH-1:0] sync_q; // second stage

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // per bit double register
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= async[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign synced = sync_q;
endmodule
`default_nettype wire

/* bench/hcp_host_port_assertions.sv */
`default_nettype none
module hcp_host_port_assertions
  import hcp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic chipSelN,
  input wire logic transfer_strobe_n,
  input wire logic serial_port_mode_sel,
  input wire logic [hcp_pkg::ADDR_W-1:0] addrIn,
  input wire logic [hcp_pkg::DATA_W-1:0] dataOut,
  input wire logic [hcp_pkg::DATA_W-1:0] dataOe,
  input wire hcp_pkg::hcp_req_t regReq,
  input wire logic [hcp_pkg::DATA_W-1:0] regRdData,
  input wire logic irqPending,
  input wire logic intOut,
  input wire logic intOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // parallel read request, first step of a read
  sequence s_par_read;
    regReq.re && !serial_port_mode_sel;
  endsequence
  a_int_open_drain: assert property (intOut == 1'b0)
    else $error("interrupt pin driven high");
  a_int_follows: assert property (intOe == irqPending)
    else $error("interrupt pull does not follow pending");
  a_sel_ignores: assert property (chipSelN [*4] |->
    !regReq.we && !regReq.re) else $error("request while deselected");
  a_oe_deselect: assert property (chipSelN [*5] |->
    dataOe == 8'h00) else $error("bus driven while deselected");
  a_read_drive: assert property (s_par_read |=>
    dataOe == 8'hff) else $error("bus not driven after read");
  a_read_data: assert property (s_par_read ##1 1'b1 |=>
    dataOut == $past(regRdData)) else $error("read data wrong");
  a_write_addr: assert property (regReq.we && !serial_port_mode_sel
    |-> regReq.addr == addrIn) else $error("write address wrong");
  a_serial_oe: assert property (serial_port_mode_sel [*4] |->
    dataOe[7:1] == 7'h00) else $error("upper bus driven in serial");
  a_reply_fall: assert property ($changed(dataOut[0]) &&
    serial_port_mode_sel && !chipSelN |-> !transfer_strobe_n)
    else $error("reply bit changed off falling clock");
endmodule

bind hcp_host_port hcp_host_port_assertions u_chk (
  .clk(clk), .nrst(nrst), .chipSelN(chipSelN),
  .transfer_strobe_n(transfer_strobe_n),
  .serial_port_mode_sel(serial_port_mode_sel), .addrIn(addrIn),
  .dataOut(dataOut), .dataOe(dataOe), .regReq(regReq),
  .regRdData(regRdData), .irqPending(irqPending),
  .intOut(intOut), .intOe(intOe)
);
`default_nettype wire

/* bench/hcp_host_model.sv */
`default_nettype none
// host controller driving the port pins
module hcp_host_model
  import hcp_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] bus,
  output logic csN,
  output logic strobeN,
  output logic rwSdi,
  output logic modeSel,
  output logic styleSel,
  output logic [10:0] addr,
  output logic [7:0] hData,
  output logic hEn
);
  timeunit 1ns;
  timeprecision 1ps;
  // select high from power-up, style pin set by each parallel access while deselected
  initial begin
    {csN, strobeN, rwSdi, modeSel, styleSel, hEn} = 6'b111000;
    {addr, hData} = '0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ==========================================
  // parallel access, one per select low period
  task automatic par(input logic st, input logic rd,
    input logic [10:0] a, input logic [7:0] d, output logic [7:0] q);
    {modeSel, styleSel, rwSdi, addr, hData, hEn} =
      {1'b0, st, 1'b1, a, d, !rd};
    tick(3);
    csN = 1'b0;
    tick(3);
    if (st == STYLE_DIR_STROBE) {strobeN, rwSdi} = {1'b0, rd};
    else if (rd) strobeN = 1'b0;
    else rwSdi = 1'b0;
    tick(8);
    q = bus;
    {strobeN, rwSdi} = 2'b11;
    tick(4);
    {csN, hEn} = 2'b10;
    tick(6);
  endtask
  // ==========================================
  // serial frame, clock idles high between frames
  task automatic spi(input logic rd, input logic [10:0] a,
    input logic [7:0] d, output logic [7:0] q);
    logic [19:0] f;
    f = {rd, a, d};
    {modeSel, addr, hData, hEn} = {1'b1, 19'h0, 1'b1};
    tick(4);
    csN = 1'b0;
    tick(4);
    for (int i = 19; i >= 0; i--) begin
      {strobeN, rwSdi} = {1'b0, f[i]};
      tick(20);
      strobeN = 1'b1;
      q[i[2:0]] = bus[0];
      tick(20);
    end
    csN = 1'b1;
    tick(6);
  endtask
  // strobe toggled while deselected
  task automatic glitch();
    modeSel = 1'b0;
    tick(4);
    strobeN = 1'b0;
    tick(8);
    strobeN = 1'b1;
    tick(8);
  endtask
endmodule
`default_nettype wire

/* bench/hcp_host_port_tb.sv */
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin \
  miscompares++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module hcp_host_port_tb;
  import hcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, irqPending, intOut, intOe, testMode, rd, st;
  logic csN, strobeN, rwSdi, modeSel, styleSel, hEn;
  logic [10:0] addr, a;
  logic [7:0] hData, dataOut, dataOe, q, d;
  logic [7:0] regRdData = 8'h00;
  wire logic [7:0] bus;
  hcp_req_t regReq, e;
  hcp_req_t expQ[$];
  int cyc = 0, miscompares = 0, comparisons = 0, seed;
  // released bus lines toggle every cycle while the host is not driving them (hEn low)
  assign bus = (dataOe & dataOut)
    | (~dataOe & (hEn ? hData : {8{cyc[0]}}));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  hcp_host_model u_host (.clk(clk), .bus(bus), .csN(csN),
    .strobeN(strobeN), .rwSdi(rwSdi), .modeSel(modeSel),
    .styleSel(styleSel), .addr(addr), .hData(hData), .hEn(hEn));
  hcp_host_port u_dut (.clk(clk), .nrst(nrst), .chipSelN(csN),
    .transfer_strobe_n(strobeN), .rwWrSerialCmdIn(rwSdi),
    .serial_port_mode_sel(modeSel), .parallel_style_sel(styleSel),
    .addrIn(addr), .dataIn(bus), .dataOut(dataOut), .dataOe(dataOe),
    .regReq(regReq), .regRdData(regRdData), .irqPending(irqPending),
    .intOut(intOut), .intOe(intOe), .testModeActive(testMode));
  // register file stand-in, data the cycle after a read
  always @(posedge clk) if (regReq.re) regRdData <= regReq.addr[7:0] ^ 8'ha5;
  // ==========================================
  // request monitor against the expectation queue
  always @(posedge clk) begin
    if (nrst && (regReq.we || regReq.re)) begin
      if (expQ.size() == 0) `CHK("spurious", 1'b0, 1'b1)
      else begin
        e = expQ.pop_front();
        `CHK("req", {e.we, e.re, e.addr}, {regReq.we, regReq.re, regReq.addr})
        if (e.we) `CHK("wdata", e.wdata, regReq.wdata)
      end
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    {nrst, irqPending} = 2'b00;
    seed = $urandom(32'ha362f4a0);
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    `CHK("testmode", 1'b1, testMode)
    repeat (6) @(posedge clk);
    #1 `CHK("testmode", 1'b0, testMode)
    note("reset");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      #1 irqPending = i[0];
      #1 `CHK("intOe", i[0], intOe)
      `CHK("intOut", 1'b0, intOut)
    end
    note("irq");
    for (int i = 0; i < 12; i++) begin
      a = (i < 2) ? {11{i[0]}} : 11'($urandom);
      d = 8'($urandom);
      {st, rd} = i[1:0];
      if (i < 8) begin
        expQ.push_back({!rd, rd, a, d});
        u_host.par(st, rd, a, d, q);
      end else begin
        expQ.push_back({!rd, rd, a, d});
        u_host.spi(rd, a, d, q);
      end
      if (rd) `CHK("rdata", a[7:0] ^ 8'ha5, q)
    end
    note("access");
    u_host.glitch();
    `CHK("pending", 0, expQ.size())
    note("deselect");
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire
